// ### design/gpio_pin_mux.sv
// Pin multiplexer of one port: port logic or alternate function per bit.
// Assumes the caller registers its outputs.
`timescale 1ns/100ps
module gpio_pin_mux #(
  parameter int W = 6
) (
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] func,
  input  wire logic [W-1:0] altOut,
  input  wire logic [W-1:0] altOe,
  output logic      [W-1:0] pinOut,
  output logic      [W-1:0] pinOe
);

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (func[i])
      begin
        pinOut[i] = altOut[i];
        pinOe[i]  = altOe[i];
      end
      else
      begin
        pinOut[i] = latch[i];
        pinOe[i]  = ~dir[i];
      end
    end
  end

endmodule

// ### design/gpio_ports_four_and_five.sv
// Two GPIO ports (3 and 6 pins) behind an APB slave.
// Assumes pins and peripheral signals are synchronous to clk.
`timescale 1ns/100ps
module gpio_ports_four_and_five
  import gpio_ports_pkg::*;
(
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [31:0]                        paddr,
  input  wire logic [31:0]                        pwdata,
  input  wire logic [3:0]                         pstrb,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic [gpio_ports_pkg::WIDTH_A-1:0] portAPinIn,
  output logic      [gpio_ports_pkg::WIDTH_A-1:0] portAPinOut,
  output logic      [gpio_ports_pkg::WIDTH_A-1:0] portAPinOe,
  output logic      [gpio_ports_pkg::WIDTH_A-1:0] portAPullup,
  output logic      [gpio_ports_pkg::WIDTH_A-1:0] portAFuncEn,
  input  wire logic                               serialDataOut,
  input  wire logic                               serialClockOut,
  input  wire logic                               serialClockOe,
  input  wire logic [gpio_ports_pkg::WIDTH_B-1:0] portBPinIn,
  output logic      [gpio_ports_pkg::WIDTH_B-1:0] portBPinOut,
  output logic      [gpio_ports_pkg::WIDTH_B-1:0] portBPinOe,
  output logic      [gpio_ports_pkg::WIDTH_B-1:0] portBPullup,
  output logic      [gpio_ports_pkg::WIDTH_B-1:0] portBFuncEn,
  output logic      [gpio_ports_pkg::WIDTH_B-1:0] portBFuncSel,
  output logic      [gpio_ports_pkg::WIDTH_B-1:0] portBFuncSelExt,
  input  wire logic [gpio_ports_pkg::WIDTH_B-1:0] timerOut,
  input  wire logic                               debugResetPin,
  input  wire logic                               debugDataOut,
  input  wire logic                               debugDataOe,
  output logic                                    debugModeEnable,
  output logic                                    debugResetPullDown
);
  import gpio_ports_pkg::*;

  gpio_state_t        cur;
  gpio_state_t        next_cur;
  logic [WIDTH_A-1:0] aAltOut;
  logic [WIDTH_A-1:0] aAltOe;
  logic [WIDTH_B-1:0] bAltOut;
  logic [WIDTH_B-1:0] bAltOe;
  logic [WIDTH_A-1:0] aMuxOut;
  logic [WIDTH_A-1:0] aMuxOe;
  logic [WIDTH_B-1:0] bMuxOut;
  logic [WIDTH_B-1:0] bMuxOe;
  logic               setup;
  logic               access;
  logic               debugOwns;
  logic [7:0]         debugWord;

  // ****************************************
  // Helper functions
  // ****************************************

  // Byte write, or a single-bit write when the bit-mode flag is set
  function automatic logic [7:0] applyWrite(input logic [7:0]  old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  strb);
    logic [7:0] res;
    res = old;
    if (wdata[BIT_MODE_POS])
      res[wdata[BIT_INDEX_LSB +: 3]] = wdata[0];
    else if (strb[0])
      res = wdata[7:0];
    return res;
  endfunction

  // Input-mode bits read the pin, output-mode bits the latch
  function automatic logic [7:0] readPort(input logic [7:0] latch,
                                          input logic [7:0] dir,
                                          input logic [7:0] pins);
    return (latch & ~dir) | (pins & dir);
  endfunction

  // ****************************************
  // Alternate-function routing
  // ****************************************
  assign debugOwns = cur.debugEn & debugResetPin;
  assign debugWord = applyWrite({7'h00, cur.debugEn}, pwdata, pstrb);

  always_comb
  begin
    // Serial data in is input only, data out drives, clock follows the peripheral
    aAltOut = {serialClockOut, serialDataOut, 1'b0};
    aAltOe  = {serialClockOe, 1'b1, 1'b0};
    for (int i = 0; i < WIDTH_B; i++)
    begin
      bAltOut[i] = timerOut[i];
      // Only the output code drives; input and prohibited codes leave it released
      bAltOe[i]  = ({cur.bSelExt[i], cur.bSel[i]} == FUNC_OUT);
    end
  end

  gpio_pin_mux #(
    .W (WIDTH_A)
  ) u_mux_a (
    .latch  (cur.aData[WIDTH_A-1:0]),
    .dir    (cur.aDir[WIDTH_A-1:0]),
    .func   (cur.aFunc[WIDTH_A-1:0]),
    .altOut (aAltOut),
    .altOe  (aAltOe),
    .pinOut (aMuxOut),
    .pinOe  (aMuxOe)
  );

  gpio_pin_mux #(
    .W (WIDTH_B)
  ) u_mux_b (
    .latch  (cur.bData[WIDTH_B-1:0]),
    .dir    (cur.bDir[WIDTH_B-1:0]),
    .func   (cur.bFunc[WIDTH_B-1:0]),
    .altOut (bAltOut),
    .altOe  (bAltOe),
    .pinOut (bMuxOut),
    .pinOe  (bMuxOe)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  assign setup  = psel & ~penable;
  assign access = psel & penable & cur.pready;

  always_comb
  begin
    next_cur = cur;

    // Pin drivers, one cycle behind the registers
    next_cur.aPinOut = aMuxOut;
    next_cur.aPinOe  = aMuxOe;
    next_cur.bPinOut = bMuxOut;
    next_cur.bPinOe  = bMuxOe;
    // Debug pins take over the shared pins while the debug function holds them
    if (debugOwns)
    begin
      next_cur.bPinOut[DEBUG_PINS_LSB+1] = debugDataOut;
      next_cur.bPinOe[DEBUG_PINS_LSB +: 4] = {2'h0, debugDataOe, 1'h0};
    end

    // Ready in the first access cycle; read data captured at setup
    next_cur.pready  = setup;
    next_cur.pslverr = 1'b0;
    if (setup)
    begin
      next_cur.prdata = 32'h00000000;
      unique case (paddr)
        ADDR_A_DATA:   next_cur.prdata[7:0] = readPort(cur.aData, cur.aDir,
                                                       {5'h00, portAPinIn});
        ADDR_A_DIR:    next_cur.prdata[7:0] = cur.aDir;
        ADDR_A_FUNC:   next_cur.prdata[7:0] = cur.aFunc;
        ADDR_A_PULLUP: next_cur.prdata[7:0] = cur.aPullup;
        ADDR_B_DATA:   next_cur.prdata[7:0] = readPort(cur.bData, cur.bDir,
                                                       {2'h0, portBPinIn});
        ADDR_B_DIR:    next_cur.prdata[7:0] = cur.bDir;
        ADDR_B_FUNC:   next_cur.prdata[7:0] = cur.bFunc;
        ADDR_B_SEL:    next_cur.prdata[7:0] = cur.bSel;
        ADDR_B_SELEXT: next_cur.prdata[7:0] = cur.bSelExt;
        ADDR_B_PULLUP: next_cur.prdata[7:0] = cur.bPullup;
        ADDR_DEBUG:    next_cur.prdata[0]   = cur.debugEn;
        default:       next_cur.pslverr     = 1'b1;
      endcase
    end
    else if (cur.pready)
      next_cur.pslverr = cur.pslverr;

    // Writes take effect at the access edge; unused bits keep fixed levels
    if (access && pwrite)
    begin
      unique case (paddr)
        ADDR_A_DATA:   next_cur.aData   = applyWrite(cur.aData, pwdata, pstrb) & 8'h07;
        ADDR_A_DIR:    next_cur.aDir    = applyWrite(cur.aDir, pwdata, pstrb) | 8'hF8;
        ADDR_A_FUNC:   next_cur.aFunc   = applyWrite(cur.aFunc, pwdata, pstrb) & 8'h07;
        ADDR_A_PULLUP: next_cur.aPullup = applyWrite(cur.aPullup, pwdata, pstrb) & 8'h07;
        ADDR_B_DATA:   next_cur.bData   = applyWrite(cur.bData, pwdata, pstrb) & 8'h3F;
        ADDR_B_DIR:    next_cur.bDir    = applyWrite(cur.bDir, pwdata, pstrb) | 8'hC0;
        ADDR_B_FUNC:   next_cur.bFunc   = applyWrite(cur.bFunc, pwdata, pstrb) & 8'h3F;
        ADDR_B_SEL:    next_cur.bSel    = applyWrite(cur.bSel, pwdata, pstrb) & 8'h3F;
        ADDR_B_SELEXT: next_cur.bSelExt = applyWrite(cur.bSelExt, pwdata, pstrb) & 8'h3F;
        ADDR_B_PULLUP: next_cur.bPullup = applyWrite(cur.bPullup, pwdata, pstrb) & 8'h3F;
        ADDR_DEBUG:    next_cur.debugEn = debugWord[0];
        default:       next_cur.debugEn = cur.debugEn;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur         <= '0;
      cur.aData   <= RST_DATA;
      cur.bData   <= RST_DATA;
      cur.aDir    <= RST_DIR;
      cur.bDir    <= RST_DIR;
      cur.aFunc   <= RST_FUNC;
      cur.bFunc   <= RST_FUNC;
      cur.bSel    <= RST_SEL;
      cur.bSelExt <= RST_SEL;
      cur.aPullup <= RST_PULLUP;
      cur.bPullup <= RST_PULLUP;
      cur.debugEn <= RST_DEBUG_EN;
    end
    else
      cur <= next_cur;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata             = cur.prdata;
  assign pready             = cur.pready;
  assign pslverr            = cur.pslverr;
  assign portAPinOut        = cur.aPinOut;
  assign portAPinOe         = cur.aPinOe;
  assign portAPullup        = cur.aPullup[WIDTH_A-1:0];
  assign portAFuncEn        = cur.aFunc[WIDTH_A-1:0];
  assign portBPinOut        = cur.bPinOut;
  assign portBPinOe         = cur.bPinOe;
  assign portBPullup        = cur.bPullup[WIDTH_B-1:0];
  assign portBFuncEn        = cur.bFunc[WIDTH_B-1:0];
  assign portBFuncSel       = cur.bSel[WIDTH_B-1:0];
  assign portBFuncSelExt    = cur.bSelExt[WIDTH_B-1:0];
  assign debugModeEnable    = cur.debugEn;
  assign debugResetPullDown = cur.debugEn;

endmodule

// ### design/gpio_ports_pkg.sv
// Constants, register map and state types for the two-port GPIO block.
// Assumes an APB slave with 32-bit address and data, one register per word.
package gpio_ports_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [31:0] ADDR_A_DATA    = 32'hFFFFF408;
  localparam logic [31:0] ADDR_A_DIR     = 32'hFFFFF428;
  localparam logic [31:0] ADDR_A_FUNC    = 32'hFFFFF448;
  localparam logic [31:0] ADDR_A_PULLUP  = 32'hFFFFFC48;
  localparam logic [31:0] ADDR_B_DATA    = 32'hFFFFF40C;
  localparam logic [31:0] ADDR_B_DIR     = 32'hFFFFF42C;
  localparam logic [31:0] ADDR_B_FUNC    = 32'hFFFFF44C;
  localparam logic [31:0] ADDR_B_SEL     = 32'hFFFFF46C;
  localparam logic [31:0] ADDR_B_SELEXT  = 32'hFFFFF70C;
  localparam logic [31:0] ADDR_B_PULLUP  = 32'hFFFFFC4C;
  localparam logic [31:0] ADDR_DEBUG     = 32'hFFFFF9FC;

  // ****************************************
  // Field layout of a write word, port widths and first debug pin
  // ****************************************
  localparam int          BIT_MODE_POS   = 31;
  localparam int          BIT_INDEX_LSB  = 8;
  localparam int          WIDTH_A        = 3;
  localparam int          WIDTH_B        = 6;
  localparam int          DEBUG_PINS_LSB = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  RST_DATA       = 8'h00;
  localparam logic [7:0]  RST_DIR        = 8'hFF;
  localparam logic [7:0]  RST_FUNC       = 8'h00;
  localparam logic [7:0]  RST_SEL        = 8'h00;
  localparam logic [7:0]  RST_PULLUP     = 8'h00;
  localparam logic        RST_DEBUG_EN   = 1'b1;

  // ****************************************
  // Second-port function codes {ext, sel}
  // ****************************************
  localparam logic [1:0]  FUNC_IN        = 2'h1;
  localparam logic [1:0]  FUNC_OUT       = 2'h2;

  typedef struct packed {
    logic [7:0]         aData;
    logic [7:0]         aDir;
    logic [7:0]         aFunc;
    logic [7:0]         aPullup;
    logic [7:0]         bData;
    logic [7:0]         bDir;
    logic [7:0]         bFunc;
    logic [7:0]         bSel;
    logic [7:0]         bSelExt;
    logic [7:0]         bPullup;
    logic               debugEn;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [WIDTH_A-1:0] aPinOut;
    logic [WIDTH_A-1:0] aPinOe;
    logic [WIDTH_B-1:0] bPinOut;
    logic [WIDTH_B-1:0] bPinOe;
  } gpio_state_t;

endpackage

// ### tb/gpio_pin_world.sv
// Outside world of one port: what each pin settles to.
// Assumes ext is the level an outside source puts on a released pin.
`timescale 1ns/100ps
module gpio_pin_world #(
  parameter int W = 3
) (
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pullEn,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] pinIn
);
  // Driven pin shows the drive, else the pull-up, else the outside level
  always_comb
  begin
    for (int i = 0; i < W; i++)
      pinIn[i] = pinOe[i] ? pinOut[i] : (pullEn[i] ? 1'b1 : ext[i]);
  end
endmodule

// ### tb/gpio_ports_chk.sv
// Concurrent checks of the GPIO block's bus and register-output relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module gpio_ports_chk
  import gpio_ports_pkg::*;
(
  input wire logic                               clk,
  input wire logic                               rst,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [31:0]                        paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic [3:0]                         pstrb,
  input wire logic [31:0]                        prdata,
  input wire logic                               pready,
  input wire logic                               pslverr,
  input wire logic [gpio_ports_pkg::WIDTH_A-1:0] portAPullup,
  input wire logic [gpio_ports_pkg::WIDTH_A-1:0] portAPinOe,
  input wire logic [gpio_ports_pkg::WIDTH_B-1:0] portBPinOe,
  input wire logic [gpio_ports_pkg::WIDTH_B-1:0] portBFuncEn,
  input wire logic                               debugModeEnable,
  input wire logic                               debugResetPullDown
);
  // ****************************************
  // Helper logic and assertions
  // ****************************************
  logic        acc;
  logic        mapped;
  logic [31:0] wCap;
  logic [2:0]  pullPrev;
  logic [2:0]  bm;
  assign acc = psel && penable && pready && pwrite;
  assign mapped = paddr inside {ADDR_A_DATA, ADDR_A_DIR, ADDR_A_FUNC, ADDR_A_PULLUP, ADDR_B_DATA, ADDR_B_DIR,
                                ADDR_B_FUNC, ADDR_B_SEL, ADDR_B_SELEXT, ADDR_B_PULLUP, ADDR_DEBUG};
  assign bm = 3'h1 << wCap[10:8];
  always_ff @(posedge clk)
  begin
    if (acc)
    begin
      wCap <= pwdata;
      pullPrev <= portAPullup;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no answer one cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_pullup_byte: assert property (acc && paddr == ADDR_A_PULLUP && !pwdata[31] && pstrb[0]
    |-> ##[1:2] portAPullup == wCap[2:0]) else $error("pull-up byte write lost");
  a_func_byte: assert property (acc && paddr == ADDR_B_FUNC && !pwdata[31] && pstrb[0]
    |-> ##[1:2] portBFuncEn == wCap[5:0]) else $error("mode byte write lost");
  a_bit_write: assert property (acc && paddr == ADDR_A_PULLUP && pwdata[31]
    |-> ##[1:2] portAPullup == ((pullPrev & ~bm) | (bm & {3{wCap[0]}}))) else $error("bit write disturbed");
  a_debug_pull: assert property (!debugModeEnable |-> !debugResetPullDown)
    else $error("pull-down kept with debug off");
  a_reset_state: assert property (disable iff (1'b0) rst |=> !pready && portAPinOe == 3'h0
    && portBPinOe == 6'h0 && portAPullup == 3'h0 && portBFuncEn == 6'h0) else $error("bad reset state");
  c_refused: cover property (pslverr);
  c_bit_write: cover property (acc && pwdata[31]);
  c_port_b_drive: cover property (portBPinOe != 6'h0);
endmodule
bind gpio_ports_four_and_five gpio_ports_chk i_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .portAPullup, .portAPinOe, .portBPinOe, .portBFuncEn, .debugModeEnable,
  .debugResetPullDown);

// ### tb/gpio_ports_four_and_five_test.sv
// Self-checking bench of the two-port GPIO block driven over APB.
// Assumes the pin world model and the bound checker are compiled with it.
`timescale 1ns/100ps
module gpio_ports_four_and_five_test;
  import gpio_ports_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [2:0]  aIn, aOut, aOe, aPull, aFunc, aExt;
  logic [5:0]  bIn, bOut, bOe, bPull, bFunc, bSel, bSelExt, timerOut, bExt;
  logic        serDo, serCk, serCkOe, dbgRst, dbgDo, dbgOe, dbgEn, dbgPd;
  logic [7:0]  v, dirB, latB, pullB;
  int          mismatches, total_checks, seed, i;

  gpio_ports_four_and_five i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .portAPinIn(aIn), .portAPinOut(aOut), .portAPinOe(aOe), .portAPullup(aPull),
    .portAFuncEn(aFunc), .serialDataOut(serDo), .serialClockOut(serCk), .serialClockOe(serCkOe),
    .portBPinIn(bIn), .portBPinOut(bOut), .portBPinOe(bOe), .portBPullup(bPull), .portBFuncEn(bFunc),
    .portBFuncSel(bSel), .portBFuncSelExt(bSelExt), .timerOut(timerOut), .debugResetPin(dbgRst),
    .debugDataOut(dbgDo), .debugDataOe(dbgOe), .debugModeEnable(dbgEn), .debugResetPullDown(dbgPd));
  gpio_pin_world #(.W(3)) i_world_a (.pinOut(aOut), .pinOe(aOe), .pullEn(aPull), .ext(aExt), .pinIn(aIn));
  gpio_pin_world #(.W(6)) i_world_b (.pinOut(bOut), .pinOe(bOe), .pullEn(bPull), .ext(bExt), .pinIn(bIn));

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      mismatches++;
  end
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
  begin
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  end
  endtask
  task automatic settle;
  begin
    repeat (2) @(posedge clk);
    #1;
  end
  endtask
  function automatic logic [31:0] expData(input logic [5:0] dir, input logic [5:0] lat, input logic [5:0] pin);
    expData = {26'h0, (dir & pin) | (~dir & lat)};
  endfunction
  task automatic conclude;
  begin
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #(25 * 20000);
    mismatches++;
    conclude;
  end
  initial
  begin
    seed = 5671;
    rst = 1'b1;
    {psel, penable, pwrite, serDo, serCk, serCkOe, dbgRst, dbgDo, dbgOe} = '0;
    {paddr, pwdata, aExt, bExt, timerOut} = '0;
    pstrb = 4'hF;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_A_DIR, 32'hFF);
    rchk(ADDR_A_PULLUP, 32'h0);
    rchk(ADDR_B_FUNC, 32'h0);
    apb(1'b0, 32'hFFFFF400, 32'h0);
    check(32'(er), 32'h1);
    aExt <= 3'h5;
    rchk(ADDR_A_DATA, 32'h5);
    apb(1'b1, ADDR_B_DIR, 32'hC0);
    rchk(ADDR_B_DATA, 32'h0);
    apb(1'b1, ADDR_A_DATA, 32'h3);
    settle;
    check(32'(aOe), 32'h0);
    apb(1'b1, ADDR_A_DIR, 32'hF8);
    settle;
    check(32'({aOe, aOut}), 32'h3B);
    v = 8'($random(seed));
    apb(1'b1, ADDR_A_DATA, {24'h0, v});
    settle;
    check(32'(aOut), 32'(v[2:0]));
    rchk(ADDR_A_DATA, 32'(v[2:0]));
    for (i = 0; i < 20; i++)
    begin
      dirB = 8'($random(seed));
      latB = 8'($random(seed));
      bExt <= 6'($random(seed));
      apb(1'b1, ADDR_B_DIR, {24'h0, dirB});
      apb(1'b1, ADDR_B_DATA, {24'h0, latB});
      rchk(ADDR_B_DATA, expData(dirB[5:0], latB[5:0], bExt));
      check(32'({bOe, bOut & ~dirB[5:0]}), 32'({~dirB[5:0], latB[5:0] & ~dirB[5:0]}));
    end
    pullB = 8'h0;
    for (i = 0; i < 16; i++)
    begin
      v = 8'($random(seed));
      apb(1'b1, ADDR_B_PULLUP, {1'b1, 20'h0, v[2:0], 7'h0, v[7]});
      if (v[2:0] < 3'h6)
        pullB[v[2:0]] = v[7];
      rchk(ADDR_B_PULLUP, {24'h0, pullB});
    end
    check(32'(bPull), 32'(pullB[5:0]));
    apb(1'b1, ADDR_A_PULLUP, 32'h3);
    apb(1'b1, ADDR_A_PULLUP, 32'h80000000);
    rchk(ADDR_A_PULLUP, 32'h2);
    serDo <= 1'b1;
    apb(1'b1, ADDR_A_FUNC, 32'h2);
    settle;
    check(32'({aOe[1], aOut[1], aFunc}), 32'h1A);
    timerOut <= 6'($random(seed));
    apb(1'b1, ADDR_B_SELEXT, 32'h8);
    apb(1'b1, ADDR_B_SEL, 32'h0);
    apb(1'b1, ADDR_B_FUNC, 32'h8);
    settle;
    check(32'({bOe[3], bOut[3]}), 32'({1'b1, timerOut[3]}));
    apb(1'b1, ADDR_B_SELEXT, 32'h0);
    apb(1'b1, ADDR_B_SEL, 32'h8);
    settle;
    check(32'(bOe[3]), 32'h0);
    check(32'({bSelExt, bSel}), 32'h008);
    @(posedge clk);
    dbgRst <= 1'b1;
    dbgDo <= 1'b1;
    dbgOe <= 1'b1;
    settle;
    check(32'({bOe[5:2], bOut[3]}), 32'h05);
    @(posedge clk);
    dbgRst <= 1'b0;
    apb(1'b1, ADDR_DEBUG, 32'h0);
    settle;
    check(32'({dbgEn, dbgPd}), 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_A_DIR, 32'hFF);
    check(32'({aOe, dbgEn, dbgPd}), 32'h3);
    conclude;
  end
endmodule
